// File: inc/agc_pkg.sv
// Purpose: Shared constants for the conversion gain and offset correction stage.
// Assumes: 12-bit unsigned converter codes, coefficients held in 16-bit memory words.
// Notes: Gain is unsigned fixed point with GAIN_FRAC fraction bits; offset is signed LSBs.
package agc_pkg;
    // ==========================================================================
    // Data formats
    localparam int ADC_W = 12;
    localparam int GAIN_W = 16;
    localparam int GAIN_FRAC = 14;
    localparam int OFF_W = 16;
    localparam logic [GAIN_W-1:0] GAIN_UNITY = 16'h4000;
    localparam logic [OFF_W-1:0] OFFSET_ZERO = 16'h0000;
    localparam logic [ADC_W-1:0] CODE_MIN = 12'h000;
    localparam logic [ADC_W-1:0] CODE_MAX = 12'hFFF;

    // ==========================================================================
    // Timing: total latency in clock cycles and how it is split.
    localparam int CAL_LATENCY = 14;
    localparam int ARITH_STAGES = 2;
    localparam int DLY_DEPTH = CAL_LATENCY - ARITH_STAGES;

    // ==========================================================================
    // Coefficient memory map, relative to the coefficient base address.
    localparam int NVM_AW = 8;
    localparam int NVM_DW = 16;
    localparam logic [NVM_AW-1:0] NVM_GAIN_OFS = 8'h00;
    localparam logic [NVM_AW-1:0] NVM_OFFSET_OFS = 8'h01;

    // ==========================================================================
    // Coefficient fetch sequencer states.
    typedef enum logic [1:0] {
        FE_IDLE = 2'b00,
        FE_GAIN = 2'b01,
        FE_OFFSET = 2'b10,
        FE_DONE = 2'b11
    } agc_fetch_t;
endpackage

// File: inc/agc_dly_if.sv
// Purpose: Carrier for a valid-qualified word between the arithmetic and the delay line.
// Assumes: Both ends run on the same clock.
// Notes: The source drives, the sink samples; there is no back-pressure.
`timescale 1ns/10ps
interface agc_dly_if #(
    parameter int W = 12
);
    logic valid;
    logic [W-1:0] data;

    // ==========================================================================
    // Port views.
    modport src (output valid, output data);
    modport snk (input valid, input data);
endinterface

// File: hw/agc_delay_line.sv
// Purpose: Fixed-depth shift register that carries corrected results to the output.
// Assumes: A new word may enter on every cycle.
// Notes: The last stage is a flip-flop, so output data never come from gates.
`timescale 1ns/10ps
module agc_delay_line #(
    parameter int W = 12,
    parameter int DEPTH = 12
) (
    input wire logic clk,
    input wire logic reset,
    agc_dly_if.snk in_port,
    agc_dly_if.src out_port,
    output logic busy
);
    // ==========================================================================
    // Elaboration check.
    if (DEPTH < 1) begin : g_bad_depth
        $error("agc_delay_line needs DEPTH of at least one");
    end

    logic [W:0] pipe_q [DEPTH];
    logic [W:0] pipe_d [DEPTH];
    logic any_valid;

    // Next values: each stage takes the one before it.
    always_comb begin
        any_valid = 1'b0;
        pipe_d[0] = {in_port.valid, in_port.data};
        for (int i = 1; i < DEPTH; i++) begin
            pipe_d[i] = pipe_q[i-1];
        end
        for (int i = 0; i < DEPTH; i++) begin
            any_valid = any_valid | pipe_q[i][W];
        end
    end

    // Registers only; reset clears every stage so no stale word escapes.
    always_ff @(posedge clk) begin
        for (int i = 0; i < DEPTH; i++) begin
            if (reset) begin
                pipe_q[i] <= '0;
            end else begin
                pipe_q[i] <= pipe_d[i];
            end
        end
    end

    assign out_port.valid = pipe_q[DEPTH-1][W];
    assign out_port.data = pipe_q[DEPTH-1][W-1:0];
    assign busy = any_valid;
endmodule

// File: hw/agc_calibrator.sv
// Purpose: Gain and offset correction of converter results, Y = gain * X + offset; rail codes pass unchanged when SAT_BYPASS is set.
// Assumes: Converter and coefficient memory run on clk; coefficient memory answers
//          each held read request with a one-cycle nvm_rvalid pulse.
// Notes: Until each coefficient arrives, unity gain or zero offset is applied in its place.
`timescale 1ns/10ps
module agc_calibrator
    import agc_pkg::*;
#(
    parameter bit SAT_BYPASS = 1'b0,
    parameter logic [NVM_AW-1:0] NVM_BASE = 8'h00
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic adc_valid,
    input wire logic adc_busy,
    input wire logic [ADC_W-1:0] adc_result,
    output logic nvm_rd,
    output logic [NVM_AW-1:0] nvm_addr,
    input wire logic [NVM_DW-1:0] nvm_rdata,
    input wire logic nvm_rvalid,
    output logic cal_ready,
    output logic conversion_valid,
    output logic conversion_busy,
    output logic [ADC_W-1:0] conversion_result
);
    localparam int PROD_W = ADC_W + GAIN_W;
    localparam int SH_W = PROD_W - GAIN_FRAC;
    localparam int SUM_W = OFF_W + 2;

    // ==========================================================================
    // Elaboration checks; the mode is fixed here and cannot move at run time.
    if (GAIN_FRAC >= GAIN_W || SUM_W <= SH_W || NVM_DW < GAIN_W) begin : g_bad_fmt
        $error("agc_calibrator number formats cannot be served");
    end
    if (DLY_DEPTH < 1) begin : g_bad_lat
        $error("agc_calibrator latency too short for its arithmetic");
    end

    // Saturation is a rail code at either end of the converter range.
    function automatic logic is_rail(input logic [ADC_W-1:0] code);
        is_rail = (code == CODE_MIN) || (code == CODE_MAX);
    endfunction

    // Clamp a signed sum back into the unsigned code range.
    function automatic logic [ADC_W-1:0] clamp(input logic signed [SUM_W-1:0] s);
        if (s < 0) begin
            clamp = CODE_MIN;
        end else if (s > $signed({{(SUM_W-ADC_W){1'b0}}, CODE_MAX})) begin
            clamp = CODE_MAX;
        end else begin
            clamp = s[ADC_W-1:0];
        end
    endfunction

    // ==========================================================================
    // Coefficient fetch
    agc_fetch_t fe_q, fe_d;
    logic [GAIN_W-1:0] gain_q, gain_d;
    logic [OFF_W-1:0] offset_q, offset_d;
    logic [NVM_AW-1:0] addr_q, addr_d;

    // Walk the two coefficient words once after reset, then stay done.
    always_comb begin
        fe_d = fe_q;
        gain_d = gain_q;
        offset_d = offset_q;
        addr_d = addr_q;
        case (fe_q)
            FE_IDLE: begin
                fe_d = FE_GAIN;
                addr_d = NVM_BASE + NVM_GAIN_OFS;
            end
            FE_GAIN: begin
                if (nvm_rvalid) begin
                    gain_d = nvm_rdata[GAIN_W-1:0];
                    fe_d = FE_OFFSET;
                    addr_d = NVM_BASE + NVM_OFFSET_OFS;
                end
            end
            FE_OFFSET: begin
                if (nvm_rvalid) begin
                    offset_d = nvm_rdata[OFF_W-1:0];
                    fe_d = FE_DONE;
                end
            end
            FE_DONE: begin
                fe_d = FE_DONE;
            end
            default: begin
                fe_d = FE_IDLE;
            end
        endcase
    end

    // Identity coefficients at reset keep early results meaningful.
    always_ff @(posedge clk) begin
        if (reset) begin
            fe_q <= FE_IDLE;
            gain_q <= GAIN_UNITY;
            offset_q <= OFFSET_ZERO;
            addr_q <= '0;
        end else begin
            fe_q <= fe_d;
            gain_q <= gain_d;
            offset_q <= offset_d;
            addr_q <= addr_d;
        end
    end

    assign nvm_rd = (fe_q == FE_GAIN) || (fe_q == FE_OFFSET);
    assign nvm_addr = addr_q;
    assign cal_ready = (fe_q == FE_DONE);

    // ==========================================================================
    // Arithmetic: multiply in stage one, add and clamp in stage two.
    logic s1_valid_q, s1_valid_d, s1_sat_q, s1_sat_d;
    logic [ADC_W-1:0] s1_raw_q, s1_raw_d;
    logic [PROD_W-1:0] s1_prod_q, s1_prod_d;
    logic [OFF_W-1:0] s1_off_q, s1_off_d;
    logic s2_valid_q, s2_valid_d;
    logic [ADC_W-1:0] s2_data_q, s2_data_d;
    logic signed [SUM_W-1:0] sum;

    // The offset is captured with the product so a coefficient update mid-flight
    // never mixes an old gain with a new offset.
    always_comb begin
        s1_valid_d = adc_valid;
        s1_raw_d = adc_result;
        s1_sat_d = is_rail(adc_result);
        s1_prod_d = PROD_W'(gain_q) * PROD_W'(adc_result);
        s1_off_d = offset_q;
        sum = $signed({{(SUM_W-SH_W){1'b0}}, s1_prod_q[PROD_W-1:GAIN_FRAC]})
            + $signed({{(SUM_W-OFF_W){s1_off_q[OFF_W-1]}}, s1_off_q});
        s2_valid_d = s1_valid_q;
        if (SAT_BYPASS && s1_sat_q) begin
            s2_data_d = s1_raw_q;
        end else begin
            s2_data_d = clamp(sum);
        end
    end

    // Arithmetic registers.
    always_ff @(posedge clk) begin
        if (reset) begin
            s1_valid_q <= 1'b0;
            s1_sat_q <= 1'b0;
            s1_raw_q <= '0;
            s1_prod_q <= '0;
            s1_off_q <= '0;
            s2_valid_q <= 1'b0;
            s2_data_q <= '0;
        end else begin
            s1_valid_q <= s1_valid_d;
            s1_sat_q <= s1_sat_d;
            s1_raw_q <= s1_raw_d;
            s1_prod_q <= s1_prod_d;
            s1_off_q <= s1_off_d;
            s2_valid_q <= s2_valid_d;
            s2_data_q <= s2_data_d;
        end
    end

    // ==========================================================================
    // Padding delay: the arithmetic needs two cycles, the rest is pure delay so
    // the latency stays constant whatever the coefficients are.
    agc_dly_if #(.W(ADC_W)) dly_in ();
    agc_dly_if #(.W(ADC_W)) dly_out ();
    logic dly_busy;

    assign dly_in.valid = s2_valid_q;
    assign dly_in.data = s2_data_q;

    agc_delay_line #(
        .W(ADC_W),
        .DEPTH(DLY_DEPTH)
    ) i_agc_delay_line (
        .clk(clk),
        .reset(reset),
        .in_port(dly_in),
        .out_port(dly_out),
        .busy(dly_busy)
    );

    // Exported handshake comes from this stage; busy covers work in flight.
    assign conversion_valid = dly_out.valid;
    assign conversion_result = dly_out.data;
    assign conversion_busy = adc_busy | s1_valid_q | s2_valid_q | dly_busy | ~cal_ready;

    // ==========================================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    logic [ADC_W-1:0] exp_res;
    logic in_sat, in_unity;
    assign exp_res = clamp($signed(SUM_W'((PROD_W'(gain_q) * PROD_W'(adc_result)) >> GAIN_FRAC))
        + $signed({{(SUM_W-OFF_W){offset_q[OFF_W-1]}}, offset_q}));
    assign in_sat = is_rail(adc_result);
    assign in_unity = (gain_q == GAIN_UNITY) && (offset_q == OFFSET_ZERO);

    a_latency_exact: assert property (adc_valid |-> ##14 conversion_valid)
        else $error("result did not appear fourteen cycles after its input");
    a_no_spurious: assert property (conversion_valid |-> $past(adc_valid, 14))
        else $error("result appeared without an input fourteen cycles earlier");
    a_gain_offset: assert property (conversion_valid && !$past(in_sat, 14)
        |-> conversion_result == $past(exp_res, 14))
        else $error("result is not gain times input plus offset");
    a_active_sat: assert property (conversion_valid && !SAT_BYPASS && $past(in_sat, 14)
        |-> conversion_result == $past(exp_res, 14))
        else $error("saturated input was not corrected in always-active mode");
    a_bypass_sat: assert property (conversion_valid && SAT_BYPASS && $past(in_sat, 14)
        |-> conversion_result == $past(adc_result, 14))
        else $error("saturated input was altered in bypass mode");
    a_unity_pass: assert property (conversion_valid && $past(in_unity, 14)
        |-> conversion_result == $past(adc_result, 14))
        else $error("unity coefficients changed the value");
    a_fetch_start: assert property ($fell(reset) |-> ##[1:2] nvm_rd)
        else $error("coefficient fetch did not start after reset");
    a_gain_capture: assert property (fe_q == FE_GAIN && nvm_rvalid
        |=> gain_q == $past(nvm_rdata[GAIN_W-1:0]) && fe_q == FE_OFFSET)
        else $error("gain word was not captured from the memory answer");
    a_busy_hold: assert property (adc_valid |=> conversion_busy [*8])
        else $error("busy dropped while a conversion was in flight");
endmodule

// File: testbench/agc_nvm_model.sv
// Purpose: Coefficient memory model that answers gain and offset reads.
// Assumes: One read is held at a time; each is answered LAT cycles after the edge that first sees it.
// Notes: Out of reset, read data change every cycle whenever no answer is given; reset holds them at 16'h5A5A.
`timescale 1ns/10ps
module agc_nvm_model
    import agc_pkg::*;
#(
    parameter logic [NVM_AW-1:0] BASE = 8'h00,
    parameter logic [NVM_DW-1:0] GAIN = 16'h4000,
    parameter logic [NVM_DW-1:0] OFFS = 16'h0000,
    parameter int LAT = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic rd,
    input wire logic [NVM_AW-1:0] addr,
    output logic [NVM_DW-1:0] rdata,
    output logic rvalid
);
    int cnt;

    // ==========================================================================
    // Read answer
    // Words are per-part values that presume the fixed converter reference.
    // Each signal is assigned once per edge, so no transient value is scheduled.
    always @(posedge clk) begin
        if (reset) begin
            cnt <= 0;
            rvalid <= 1'b0;
            rdata <= 16'h5A5A;
        end else if (rd && !rvalid && cnt == LAT) begin
            cnt <= 0;
            rvalid <= 1'b1;
            rdata <= (addr == BASE) ? GAIN : (addr == BASE + 8'h01) ? OFFS : ~rdata;
        end else begin
            cnt <= (rd && !rvalid) ? cnt + 1 : cnt;
            rvalid <= 1'b0;
            rdata <= ~rdata;
        end
    end
endmodule

// File: testbench/tb_agc_calibrator.sv
// Purpose: Self-checking bench for the gain and offset correction stage.
// Assumes: Always-active and bypass builds run side by side on the same codes.
// Notes: A scoreboard keyed on cycle number checks each value and its latency.
`timescale 1ns/10ps
module tb_agc_calibrator
    import agc_pkg::*;
;
    localparam logic [NVM_DW-1:0] GAIN_C = 16'h3000;
    localparam logic [NVM_DW-1:0] OFF_C = 16'h0003;
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic adc_valid = 1'b0;
    logic adc_busy = 1'b0;
    logic [ADC_W-1:0] adc_result = 12'h000;
    logic [1:0] rd, rv, rdy, cv, cb;
    logic [NVM_AW-1:0] addr [2];
    logic [NVM_DW-1:0] rdat [2];
    logic [ADC_W-1:0] res [2];
    int miscompares = 0;
    int n_compared = 0;
    int cyc = 0;
    logic [ADC_W-1:0] qa [$];
    logic [ADC_W-1:0] qb [$];
    int qt [$];

    // ==========================================================================
    // Builds: index 0 always-active, index 1 bypass, at different bases.
    for (genvar g = 0; g < 2; g++) begin : gen_dut
        agc_calibrator #(.SAT_BYPASS(g == 1), .NVM_BASE(8'(16 * g))) i_agc_calibrator (
            .clk(clk), .reset(reset), .adc_valid(adc_valid), .adc_busy(adc_busy),
            .adc_result(adc_result), .nvm_rd(rd[g]), .nvm_addr(addr[g]),
            .nvm_rdata(rdat[g]), .nvm_rvalid(rv[g]), .cal_ready(rdy[g]),
            .conversion_valid(cv[g]), .conversion_busy(cb[g]), .conversion_result(res[g]));
        agc_nvm_model #(.BASE(8'(16 * g)), .GAIN(GAIN_C), .OFFS(OFF_C), .LAT(30))
            i_agc_nvm_model (.clk(clk), .reset(reset), .rd(rd[g]), .addr(addr[g]),
            .rdata(rdat[g]), .rvalid(rv[g]));
    end

    // ==========================================================================
    // Clock and a cycle ceiling so a hang cannot run forever.
    always #4 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            miscompares++;
            give_verdict();
        end
    end

    function automatic logic [ADC_W-1:0] expect_val(logic [ADC_W-1:0] x, bit byp, logic r);
        int v;
        if (r !== 1'b1) return x;
        if (byp && (x == CODE_MIN || x == CODE_MAX)) return x;
        v = ((int'(GAIN_C) * int'(x)) >>> GAIN_FRAC) + int'($signed(OFF_C));
        if (v < 0) v = 0;
        if (v > 4095) v = 4095;
        return v[ADC_W-1:0];
    endfunction

    task automatic chk_word(logic [ADC_W-1:0] got, logic [ADC_W-1:0] e);
        n_compared++;
        if (got !== e) begin
            miscompares++;
            $display("ERROR t=%0t result %h expected %h", $time, got, e);
        end
    endtask

    task automatic chk_bit(logic got, logic e);
        n_compared++;
        if (got !== e) begin
            miscompares++;
            $display("ERROR t=%0t flag %b expected %b", $time, got, e);
        end
    endtask

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ==========================================================================
    // Scoreboard: expectation is fixed when the input is taken, since the
    // coefficients in use at that edge are the ones that apply.
    always @(posedge clk) begin
        if (reset) begin
            qa.delete();
            qb.delete();
            qt.delete();
        end else begin
            if (adc_valid) begin
                qa.push_back(expect_val(adc_result, 1'b0, rdy[0]));
                qb.push_back(expect_val(adc_result, 1'b1, rdy[1]));
                qt.push_back(cyc + CAL_LATENCY);
            end
            if (qt.size() > 0 && qt[0] == cyc) begin
                chk_bit(cv[0] & cv[1], 1'b1);
                chk_word(res[0], qa.pop_front());
                chk_word(res[1], qb.pop_front());
                void'(qt.pop_front());
            end else begin
                chk_bit(cv[0] | cv[1], 1'b0);
            end
        end
    end

    task automatic put(logic [ADC_W-1:0] x);
        @(posedge clk);
        adc_valid <= 1'b1;
        adc_result <= x;
    endtask

    task automatic drain();
        @(posedge clk);
        adc_valid <= 1'b0;
        for (int i = 0; i < 40 && qt.size() > 0; i++) @(negedge clk);
        chk_bit(qt.size() == 0, 1'b1);
    endtask

    // ==========================================================================
    // Scenarios
    task automatic t_prefetch();
        // Look after the edge has settled, since a reset edge updates the state in this step.
        @(negedge clk);
        chk_bit(rdy[0] | rdy[1], 1'b0);
        chk_bit(cb[0] & cb[1], 1'b1);
        put(12'h123);
        put(12'hFFF);
        put(12'h000);
        drain();
    endtask

    task automatic t_fetch();
        // The memory answers slowly, so the gain word is still being read here.
        chk_bit(rd[0] & rd[1], 1'b1);
        chk_bit(addr[0] == NVM_GAIN_OFS && addr[1] == 8'h10 + NVM_GAIN_OFS, 1'b1);
        for (int i = 0; i < 200 && rdy !== 2'b11; i++) @(negedge clk);
        chk_bit(rdy[0] & rdy[1], 1'b1);
        chk_bit(rd[0] | rd[1], 1'b0);
        chk_bit(addr[0] == NVM_OFFSET_OFS && addr[1] == 8'h10 + NVM_OFFSET_OFS, 1'b1);
    endtask

    task automatic t_correct();
        put(12'h100);
        put(12'h000);
        put(12'hFFF);
        put(12'h7FF);
        put(12'h001);
        put(12'hFFE);
        drain();
        chk_bit(cb[0] | cb[1], 1'b0);
        @(posedge clk) adc_busy <= 1'b1;
        @(negedge clk) chk_bit(cb[0] & cb[1], 1'b1);
        @(posedge clk) adc_busy <= 1'b0;
    endtask

    // A reset in mid-flight must drop the pending result and refetch.
    task automatic t_reset();
        put(12'h200);
        @(posedge clk);
        adc_valid <= 1'b0;
        reset <= 1'b1;
        @(posedge clk);
        reset <= 1'b0;
        t_prefetch();
        t_fetch();
        t_correct();
    endtask

    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        t_prefetch();
        t_fetch();
        t_correct();
        t_reset();
        give_verdict();
    end
endmodule
